// >>> rtl/clr_defs.svh
// Offsets, field positions, reset values and timing counts of the codec link control block
`ifndef CLR_DEFS_SVH
`define CLR_DEFS_SVH

// Register indices
`define CLR_IDX_RESET 7'h00
`define CLR_IDX_PWR 7'h26
`define CLR_IDX_RSVD_LO 7'h28
`define CLR_IDX_RSVD_HI 7'h59
`define CLR_IDX_VND_LO 7'h5a
`define CLR_IDX_VND_HI 7'h7a
`define CLR_IDX_ID_FIRST 7'h7c
`define CLR_IDX_ID_REV 7'h7e

// Power register fields
`define CLR_PWR_CTL_LSB 8
`define CLR_PWR_CTL_MSB 13
`define CLR_PWR_CTL_RST 6'h00

// Frame layout, bit positions counted from the frame start
`define CLR_TAG_LAST 8'h02
`define CLR_SLOT1_FIRST 8'h10
`define CLR_CMD_LAST 8'h37
`define CLR_FRAME_LAST 8'hff

// Timing
`define CLR_SYS_MHZ 125
`define CLR_XTAL_KHZ 24576
`define CLR_BITCLK_KHZ 12288
`define CLR_WARM_MIN_NS 1000
`define CLR_WARM_CYC ((`CLR_WARM_MIN_NS * `CLR_SYS_MHZ + 999) / 1000)

`endif

// >>> rtl/clr_pkg.sv
// Types shared by the codec link control block
package clr_pkg;

  // Power-down controls, bit 13 down to bit 8
  typedef struct packed {
    logic internal_clock_off;
    logic link_pwrdn;
    logic mixer_pwrdn_ref_off;
    logic mixer_pwrdn_ref_on;
    logic dac_pwrdn;
    logic adc_input_sel_pwrdn;
  } clr_pwr_ctl_t;

  // Readiness status, bit 3 down to bit 0
  typedef struct packed {
    logic ref_ok;
    logic mixer_ok;
    logic dac_ok;
    logic adc_ok;
  } clr_rdy_t;

  // Link pins driven by the controller
  typedef struct packed {
    logic sync;
    logic sdata_out;
  } clr_link_in_t;

  typedef enum logic [2:0] {ST_STRAP, ST_TEST, ST_RUN, ST_SLEEP, ST_WAKE_LO} clr_link_st_t;

  typedef struct packed {
    clr_link_st_t st;
    clr_pwr_ctl_t pwr;
    clr_rdy_t rdy;
    logic [7:0] bit_cnt;
    logic sync_prev;
    logic go;
    logic cap_en;
    logic [2:0] rx_tag;
    logic [39:0] rx_sh;
    logic [55:0] tx_sh;
    logic rsp_pend;
    logic [6:0] rsp_idx;
    logic [15:0] rsp_data;
    logic [7:0] wcnt;
    logic codec_rdy;
    logic sdata_in;
    logic test;
  } clr_state_t;

endpackage : clr_pkg

// >>> rtl/clr_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module clr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } clr_sync_st_t;

  clr_sync_st_t q_r;
  clr_sync_st_t q_nxt;

  always_comb begin
    q_nxt.meta = i_d;
    q_nxt.q = q_r.meta;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r.q;

  AST_SYNC_DELAY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_q) |-> o_q == $past(i_d, 2))
    else $error("Synchroniser output does not follow input by two cycles");

endmodule : clr_sync2
`default_nettype wire

// >>> rtl/clr_bitclk_gen.sv
// Bit clock generator: halves the sampled crystal clock
`timescale 1ns/100ps
`default_nettype none
module clr_bitclk_gen (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Sampled crystal and enable
  input wire logic i_xtal_s,
  input wire logic i_run,
  // Bit clock and its edge pulses
  output logic o_bit_clk,
  output logic o_rise,
  output logic o_fall
);
  typedef struct packed {
    logic xtal_d;
    logic bclk;
    logic rise;
    logic fall;
  } clr_gen_st_t;

  clr_gen_st_t q_r;
  clr_gen_st_t q_nxt;
  wire logic xtal_edge;

  assign xtal_edge = i_xtal_s && !q_r.xtal_d;

  always_comb begin
    q_nxt = q_r;
    q_nxt.xtal_d = i_xtal_s;
    q_nxt.rise = 1'b0;
    q_nxt.fall = 1'b0;
    if (!i_run) begin
      // Stopped clock parks low
      q_nxt.bclk = 1'b0;
    end else if (xtal_edge) begin
      q_nxt.bclk = !q_r.bclk;
      q_nxt.rise = !q_r.bclk;
      q_nxt.fall = q_r.bclk;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_bit_clk = q_r.bclk;
  assign o_rise = q_r.rise;
  assign o_fall = q_r.fall;

  AST_BITCLK_TOGGLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_run && xtal_edge) |=> $changed(o_bit_clk))
    else $error("Bit clock missed a crystal edge");
  AST_BITCLK_ONLY_ON_XTAL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_bit_clk && !$past(o_bit_clk)) |-> $past(xtal_edge))
    else $error("Bit clock rose without a crystal edge");

endmodule : clr_bitclk_gen
`default_nettype wire

// >>> rtl/clr_link_ctrl.sv
// Codec link control: bit clock, frame timing, resets, power register and identification space
`timescale 1ns/100ps
`default_nettype none
`include "clr_defs.svh"
module clr_link_ctrl import clr_pkg::*; #(
  parameter logic [7:0] ID_CHAR_ONE = 8'h51,     // Arbitrary value
  parameter logic [7:0] ID_CHAR_TWO = 8'h52,     // Arbitrary value
  parameter logic [7:0] ID_CHAR_THREE = 8'h53,   // Arbitrary value
  parameter logic [7:0] ID_REVISION = 8'h01,     // Arbitrary value
  parameter logic [15:0] VND_FIRST_VAL = 16'h0000
) (
  // System clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Link pins
  input wire logic i_cold_rst_n,
  input wire logic i_xtal,
  input wire clr_link_in_t i_link,
  output logic o_bit_clk,
  output logic o_sdata_in,
  // Section controls and status
  output clr_pwr_ctl_t o_pwr_ctl,
  output clr_rdy_t o_pwr_status,
  output logic o_codec_ready,
  output logic o_test_mode
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [7:0] WARM_LAST = 8'(`CLR_WARM_CYC - 1);

  clr_state_t q_r;
  clr_state_t q_nxt;
  wire logic rst_a;
  wire logic rst_raw;
  wire logic rst_rel;
  wire logic [2:0] pins_s;
  wire logic xtal_s;
  wire logic sync_s;
  wire logic sdo_s;
  wire logic rise_p;
  wire logic fall_p;
  wire logic [39:0] cmd_w;
  wire logic cmd_done;
  wire logic cmd_rd;
  wire logic [6:0] cmd_idx;
  wire logic [15:0] cmd_wdat;
  wire logic rd_req;
  wire logic wr_any;
  wire logic wr_reset;
  wire logic wr_pwr;
  wire logic [55:0] tx_frame;

  // ****************************************
  // Functions
  // ****************************************
  function automatic clr_rdy_t rdy_of(input clr_pwr_ctl_t p);
    clr_rdy_t r;
    r.ref_ok = !p.mixer_pwrdn_ref_off;
    r.mixer_ok = r.ref_ok && !p.mixer_pwrdn_ref_on && !p.internal_clock_off;
    r.dac_ok = r.ref_ok && !p.dac_pwrdn && !p.internal_clock_off;
    r.adc_ok = r.ref_ok && !p.adc_input_sel_pwrdn && !p.internal_clock_off;
    return r;
  endfunction : rdy_of

  function automatic logic [15:0] reg_read(input logic [6:0] idx, input clr_pwr_ctl_t p,
                                           input clr_rdy_t r);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == `CLR_IDX_PWR) begin
      // Bits 15:14 and 7:4 read zero
      v = {2'b00, p, 4'h0, r};
    end else if (idx == `CLR_IDX_ID_FIRST) begin
      v = {ID_CHAR_ONE, ID_CHAR_TWO};
    end else if (idx == `CLR_IDX_ID_REV) begin
      v = {ID_CHAR_THREE, ID_REVISION};
    end else if (idx == `CLR_IDX_VND_LO) begin
      v = VND_FIRST_VAL;
    end
    return v;
  endfunction : reg_read

  // ****************************************
  // Pin sampling and bit clock
  // ****************************************
  // Cold reset pin resets at once, with no clock needed
  assign rst_raw = i_sys_rst || !i_cold_rst_n;

  // Release waits two clocks, so no flop sees a runt release
  clr_sync2 #(
    .W(1)
  ) u_rst_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(rst_raw),
    .i_d(1'b1),
    .o_q(rst_rel)
  );

  assign rst_a = !rst_rel;

  // Pins keep being sampled during cold reset so the test strap sees them
  clr_sync2 #(
    .W(3)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_sys_rst),
    .i_d({i_xtal, i_link.sync, i_link.sdata_out}),
    .o_q(pins_s)
  );

  assign xtal_s = pins_s[2];
  assign sync_s = pins_s[1];
  assign sdo_s = pins_s[0];

  clr_bitclk_gen u_bitclk (
    .i_clk_sys(i_clk_sys),
    .i_rst(rst_a),
    .i_xtal_s(xtal_s),
    .i_run(q_r.st == ST_RUN),
    .o_bit_clk(o_bit_clk),
    .o_rise(rise_p),
    .o_fall(fall_p)
  );

  // ****************************************
  // Command decode
  // ****************************************
  assign cmd_w = {q_r.rx_sh[38:0], sdo_s};
  assign cmd_done = fall_p && q_r.cap_en && (q_r.bit_cnt == `CLR_CMD_LAST);
  assign cmd_rd = cmd_w[39];
  assign cmd_idx = cmd_w[38:32];
  assign cmd_wdat = cmd_w[19:4];
  assign rd_req = cmd_done && cmd_rd && q_r.rx_tag[2] && q_r.rx_tag[1];
  assign wr_any = cmd_done && !cmd_rd && (&q_r.rx_tag);
  // Writes elsewhere, reserved and identification space included, are dropped
  assign wr_reset = wr_any && (cmd_idx == `CLR_IDX_RESET);
  assign wr_pwr = wr_any && (cmd_idx == `CLR_IDX_PWR);

  // Slot 0 tag, slot 1 echo of the read index, slot 2 read data
  assign tx_frame = {q_r.codec_rdy, q_r.rsp_pend, q_r.rsp_pend, 13'h0000,
                     1'b0, q_r.rsp_idx, 12'h000,
                     q_r.rsp_data, 4'h0};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.rdy = rdy_of(q_r.pwr);
    q_nxt.test = (q_r.st == ST_TEST);
    case (q_r.st)
      ST_STRAP: begin
        // Any link pin high at release enters test mode
        if (sync_s || sdo_s) begin
          q_nxt.st = ST_TEST;
          q_nxt.test = 1'b1;
        end else begin
          q_nxt.st = ST_RUN;
        end
      end
      ST_TEST: begin
        // Only a reset leaves test mode
        q_nxt.st = ST_TEST;
      end
      ST_RUN: begin
        if (fall_p) begin
          q_nxt.sync_prev = sync_s;
          if (sync_s && !q_r.sync_prev) begin
            q_nxt.go = 1'b1;
            q_nxt.cap_en = 1'b0;
            q_nxt.bit_cnt = 8'h00;
            q_nxt.codec_rdy = 1'b1;
          end else if (q_r.cap_en) begin
            if (q_r.bit_cnt <= `CLR_TAG_LAST) begin
              q_nxt.rx_tag = {q_r.rx_tag[1:0], sdo_s};
            end else if (q_r.bit_cnt >= `CLR_SLOT1_FIRST && q_r.bit_cnt <= `CLR_CMD_LAST) begin
              q_nxt.rx_sh = cmd_w;
            end
            q_nxt.bit_cnt = 8'(q_r.bit_cnt + 8'h01);
            if (q_r.bit_cnt == `CLR_FRAME_LAST) begin
              q_nxt.cap_en = 1'b0;
            end
          end
        end
        if (rise_p) begin
          if (q_r.go) begin
            q_nxt.sdata_in = tx_frame[55];
            q_nxt.tx_sh = {tx_frame[54:0], 1'b0};
            q_nxt.go = 1'b0;
            q_nxt.cap_en = 1'b1;
            q_nxt.rsp_pend = 1'b0;
          end else begin
            q_nxt.sdata_in = q_r.tx_sh[55];
            q_nxt.tx_sh = {q_r.tx_sh[54:0], 1'b0};
          end
        end
        // No sample storage: audio slots go out empty, one frame at a time
        if (rd_req) begin
          q_nxt.rsp_pend = 1'b1;
          q_nxt.rsp_idx = cmd_idx;
          q_nxt.rsp_data = reg_read(cmd_idx, q_r.pwr, q_r.rdy);
        end
        if (wr_reset) begin
          q_nxt.pwr = `CLR_PWR_CTL_RST;
        end
        if (wr_pwr) begin
          q_nxt.pwr = cmd_wdat[`CLR_PWR_CTL_MSB:`CLR_PWR_CTL_LSB];
          if (cmd_wdat[`CLR_PWR_CTL_LSB + 4]) begin
            q_nxt.st = ST_SLEEP;
            q_nxt.codec_rdy = 1'b0;
            q_nxt.sdata_in = 1'b0;
            q_nxt.go = 1'b0;
            q_nxt.cap_en = 1'b0;
            q_nxt.sync_prev = 1'b0;
            q_nxt.wcnt = 8'h00;
          end
        end
      end
      ST_SLEEP: begin
        // Registers hold apart from the wake counter: the logic is fully static
        if (sync_s) begin
          if (q_r.wcnt == WARM_LAST) begin
            q_nxt.st = ST_WAKE_LO;
          end else begin
            q_nxt.wcnt = 8'(q_r.wcnt + 8'h01);
          end
        end else begin
          q_nxt.wcnt = 8'h00;
        end
      end
      ST_WAKE_LO: begin
        // Restarting early would read the wake pulse as a frame
        if (!sync_s) begin
          q_nxt.st = ST_RUN;
          q_nxt.pwr.link_pwrdn = 1'b0;
          q_nxt.wcnt = 8'h00;
        end
      end
      default: begin
        q_nxt.st = ST_STRAP;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge rst_a) begin
    if (rst_a) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_sdata_in = q_r.sdata_in;
  assign o_pwr_ctl = q_r.pwr;
  assign o_pwr_status = q_r.rdy;
  assign o_codec_ready = q_r.codec_rdy;
  assign o_test_mode = q_r.test;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (rst_a);

  sequence seq_wake_hold;
    q_r.st == ST_WAKE_LO && sync_s;
  endsequence

  sequence seq_wake_exit;
    q_r.st == ST_WAKE_LO && !sync_s;
  endsequence

  sequence seq_warm_done;
    q_r.st == ST_SLEEP ##1 q_r.st == ST_WAKE_LO;
  endsequence

  AST_COLD_DEFAULTS: assert property (
    q_r.st == ST_STRAP |-> q_r.pwr == `CLR_PWR_CTL_RST && !o_codec_ready && !o_bit_clk)
    else $error("State after cold reset is not the default");
  AST_FRAME_START: assert property (
    (rise_p && q_r.go) |=> o_sdata_in == q_r.codec_rdy && q_r.cap_en && q_r.bit_cnt == 8'h00)
    else $error("First bit after the frame edge is not the ready tag");
  AST_DATA_ON_RISE: assert property (
    ($changed(o_sdata_in) && q_r.st == ST_RUN) |-> $past(rise_p))
    else $error("Serial data changed away from a rising bit clock edge");
  AST_CAPTURE_ON_FALL: assert property (
    $changed(q_r.bit_cnt) |-> $past(fall_p))
    else $error("Capture advanced away from a falling bit clock edge");
  AST_LINK_STOP: assert property (
    $rose(q_r.pwr.link_pwrdn) |=> (!o_bit_clk && !o_codec_ready)[*4])
    else $error("Link kept running after link power-down");
  AST_WARM_MIN: assert property (
    seq_warm_done |-> $past(q_r.wcnt) == WARM_LAST && $past(sync_s))
    else $error("Warm reset accepted on a short SYNC pulse");
  AST_WAIT_LOW: assert property (
    seq_wake_hold |=> q_r.st == ST_WAKE_LO && !o_bit_clk)
    else $error("Bit clock restarted while SYNC still high");
  AST_WARM_CLEARS: assert property (
    seq_wake_exit |=> q_r.st == ST_RUN && !o_pwr_ctl.link_pwrdn && o_pwr_ctl[5] == $past(o_pwr_ctl[5]))
    else $error("Wake-up did not clear only the link power-down control");
  AST_REG_RESET: assert property (
    (wr_reset && q_r.st == ST_RUN) |=> q_r.pwr == `CLR_PWR_CTL_RST && q_r.st == ST_RUN)
    else $error("Register reset did not restore only the controls");
  AST_PWR_FIELD: assert property (
    wr_pwr |=> q_r.pwr == $past(cmd_wdat[`CLR_PWR_CTL_MSB:`CLR_PWR_CTL_LSB]))
    else $error("Power controls not taken from bits 8 to 13");
  AST_STATUS_RO: assert property (
    wr_pwr |=> ##1 o_pwr_status == rdy_of(o_pwr_ctl))
    else $error("Status bits took written values instead of section readiness");
  AST_TEST_HOLD: assert property (
    q_r.st == ST_TEST |=> q_r.st == ST_TEST && o_test_mode && !o_bit_clk && !o_codec_ready)
    else $error("Test mode left without a reset");

endmodule : clr_link_ctrl
`default_nettype wire

// >>> rtl/clr_sync2_fix.sv
// (unused)

// >>> tb/clr_ctrl_model.sv
// Controller model: drives SYNC and serial data, captures the block's frames
`timescale 1ns/100ps
`default_nettype none
module clr_ctrl_model import clr_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link from the block
  input wire logic i_bit_clk,
  input wire logic i_sdata_in,
  // Bench control
  input wire logic [55:0] i_frame,
  input wire clr_link_in_t i_hold,
  // Link pins and received frames
  output clr_link_in_t o_link,
  output logic o_frame_start,
  output logic o_rx_done,
  output logic [55:0] o_rx
);
  // ****************************************
  // Frame engine
  // ****************************************
  logic bclk_q;
  logic [7:0] cnt_r;
  logic [55:0] tx_r;
  logic sync_r;
  logic sd_r;

  // Held pins let the bench strap test mode or send a warm wake pulse
  assign o_link = {sync_r | i_hold.sync, sd_r | i_hold.sdata_out};

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bclk_q <= 1'b0;
      cnt_r <= 8'hff;
      tx_r <= '0;
      sync_r <= 1'b0;
      sd_r <= 1'b0;
      o_frame_start <= 1'b0;
      o_rx_done <= 1'b0;
      o_rx <= '0;
    end else begin
      bclk_q <= i_bit_clk;
      o_frame_start <= 1'b0;
      o_rx_done <= 1'b0;
      if (i_bit_clk && !bclk_q) begin
        // Launch on rise, every frame 256 bit clocks, no pause between frames
        cnt_r <= cnt_r + 8'h01;
        sd_r <= (cnt_r < 8'h38) ? tx_r[8'h37 - cnt_r] : 1'b0;
        if (cnt_r == 8'hff) begin
          sync_r <= 1'b1;
          tx_r <= i_frame;
          o_frame_start <= 1'b1;
        end
        if (cnt_r == 8'h0f) begin
          sync_r <= 1'b0;
        end
      end
      if (!i_bit_clk && bclk_q && cnt_r >= 8'h01 && cnt_r <= 8'h38) begin
        o_rx <= {o_rx[54:0], i_sdata_in};
        o_rx_done <= (cnt_r == 8'h38);
      end
    end
  end
endmodule : clr_ctrl_model
`default_nettype wire

// >>> tb/test_clr_link_ctrl.sv
// Self-checking bench for the codec link control block
`timescale 1ns/100ps
`default_nettype none
module test_clr_link_ctrl import clr_pkg::*;;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam logic [7:0] ID1 = 8'h4b; // Arbitrary value
  localparam logic [7:0] ID2 = 8'h4c; // Arbitrary value
  localparam logic [7:0] ID3 = 8'h4d; // Arbitrary value
  localparam logic [7:0] REV = 8'h07; // Arbitrary value
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cold_n = 1'b1;
  logic xtal = 1'b0;
  logic [55:0] frame_bits = '0;
  clr_link_in_t hold = '0;
  clr_link_in_t link;
  logic bit_clk, sdata_in, codec_ready, test_mode, frame_start, rx_done, model_rst;
  clr_pwr_ctl_t pwr_ctl;
  clr_rdy_t pwr_status;
  logic [55:0] rx;
  logic [22:0] exp_q[$];
  int fails = 0;
  int check_count = 0;

  assign model_rst = sys_rst | ~cold_n;

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Crystal runs free, phase unrelated to the system clock
  initial begin
    // Fractional offset keeps crystal edges off the system clock edges
    #3.3;
    forever #62.5 xtal = ~xtal;
  end

  clr_link_ctrl #(.ID_CHAR_ONE(ID1), .ID_CHAR_TWO(ID2), .ID_CHAR_THREE(ID3), .ID_REVISION(REV)) u_clr_link_ctrl (
    .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_cold_rst_n(cold_n), .i_xtal(xtal), .i_link(link),
    .o_bit_clk(bit_clk), .o_sdata_in(sdata_in), .o_pwr_ctl(pwr_ctl), .o_pwr_status(pwr_status),
    .o_codec_ready(codec_ready), .o_test_mode(test_mode));

  clr_ctrl_model u_clr_ctrl_model (
    .i_clk_sys(clk_sys), .i_rst(model_rst), .i_bit_clk(bit_clk), .i_sdata_in(sdata_in),
    .i_frame(frame_bits), .i_hold(hold), .o_link(link), .o_frame_start(frame_start),
    .o_rx_done(rx_done), .o_rx(rx));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic wait_val(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk(s, v);
  endtask : wait_val

  task automatic wait_ctl(input clr_pwr_ctl_t exp);
    int n;
    n = 0;
    while (pwr_ctl !== exp && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(pwr_ctl, exp);
  endtask : wait_ctl

  task automatic count_rises(input int cyc_n, output int n);
    logic q;
    n = 0;
    q = bit_clk;
    repeat (cyc_n) begin
      @(negedge clk_sys);
      if (bit_clk === 1'b1 && q === 1'b0) n++;
      q = bit_clk;
    end
  endtask : count_rises

  // One command per frame; returns once the model has taken it
  task automatic send(input logic [55:0] f);
    int n;
    n = 0;
    @(posedge clk_sys);
    frame_bits <= f;
    while (frame_start !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    frame_bits <= '0;
  endtask : send

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    send({16'he000, 1'b0, idx, 12'h000, d, 4'h0});
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
    exp_q.push_back({idx, exp});
    send({16'hc000, 1'b1, idx, 32'h0});
  endtask : rd

  // ****************************************
  // Response watcher
  // ****************************************
  always @(negedge clk_sys) begin
    if (rx_done === 1'b1) begin
      chk(rx[55], 1'b1);
      if (rx[54] === 1'b1) begin
        if (exp_q.size() == 0) chk(rx[54], 1'b0);
        else chk({rx[38:32], rx[19:4]}, exp_q.pop_front());
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    logic [15:0] r;
    void'($urandom(32'h2560));
    cyc(10);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    count_rises(2000, n);
    chk(n >= 63 && n <= 65, 1'b1);
    wait_val(codec_ready, 1'b1, 20000);
    // Reserved range 28h-59h is never written
    r = 16'($urandom());
    wr(7'h7a, r);
    r = 16'($urandom());
    wr(7'h7c, r);
    rd(7'h7a, 16'h0000);
    rd(7'h7c, {ID1, ID2});
    rd(7'h7e, {ID3, REV});
    r = 16'($urandom());
    wr(7'h26, {8'hc5, r[7:0]});
    wait_ctl(6'h05);
    cyc(2);
    chk(pwr_status, 4'ha);
    rd(7'h26, 16'h050a);
    wr(7'h00, r);
    wait_ctl(6'h00);
    chk(codec_ready, 1'b1);
    cyc(2);
    chk(pwr_status, 4'hf);
    wr(7'h26, 16'h0302);
    wait_ctl(6'h03);
    wr(7'h26, 16'h1302);
    wait_ctl(6'h13);
    count_rises(100, n);
    chk(n, 0);
    chk(codec_ready, 1'b0);
    // Short SYNC pulse must not wake the link
    @(posedge clk_sys);
    hold <= 2'b10;
    cyc(60);
    @(posedge clk_sys);
    hold <= 2'b00;
    count_rises(200, n);
    chk(n, 0);
    @(posedge clk_sys);
    hold <= 2'b10;
    count_rises(200, n);
    chk(n, 0);
    @(posedge clk_sys);
    hold <= 2'b00;
    wait_val(bit_clk, 1'b1, 100);
    chk(pwr_ctl, 6'h03);
    wait_val(codec_ready, 1'b1, 20000);
    @(posedge clk_sys);
    cold_n <= 1'b0;
    @(negedge clk_sys);
    chk(pwr_ctl, 6'h00);
    cyc(125);
    chk(bit_clk, 1'b0);
    @(posedge clk_sys);
    cold_n <= 1'b1;
    wait_val(codec_ready, 1'b1, 20000);
    // Strap test mode with SYNC high across a cold reset
    @(posedge clk_sys);
    cold_n <= 1'b0;
    hold <= 2'b10;
    cyc(125);
    @(posedge clk_sys);
    cold_n <= 1'b1;
    cyc(10);
    chk(test_mode, 1'b1);
    count_rises(300, n);
    chk(n, 0);
    @(posedge clk_sys);
    cold_n <= 1'b0;
    hold <= 2'b00;
    cyc(125);
    @(posedge clk_sys);
    cold_n <= 1'b1;
    cyc(10);
    chk(test_mode, 1'b0);
    wait_val(bit_clk, 1'b1, 100);
    chk(exp_q.size(), 0);
    end_sim();
  end

  // About eleven frames of 8000 cycles are expected
  initial begin
    repeat (110000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule : test_clr_link_ctrl
`default_nettype wire
